/* design/ooktx_pkg.sv */
package ooktx_pkg;

  // Clock and timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_WARMUP_US = 400;
  localparam int OSC_WARMUP_CYC = OSC_WARMUP_US * 1000 / CLK_PERIOD_NS;
  localparam int SYNTH_SETTLE_US = 370;
  localparam int SYNTH_SETTLE_CYC = SYNTH_SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam int STOP_STEP_MS = 10;
  localparam int STOP_STEP_CYC = STOP_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STOP_MIN_MS = 20;
  localparam int STOP_SEL_BASE = STOP_MIN_MS / STOP_STEP_MS;
  localparam int REINIT_MS = 1;
  localparam int REINIT_CYC = REINIT_MS * 1000000 / CLK_PERIOD_NS;
  // One envelope step per 2^(sel-1) cycles gives 2^(sel-1) us per ramp.
  localparam int RAMP_STEPS = 1000 / CLK_PERIOD_NS;
  localparam int RAMP_SEL_MAX = 11;

  // Counter widths.
  localparam int TIMER_W = 16;
  localparam int IDLE_W = 24;
  localparam int CAL_W = 17;
  localparam int ENV_W = 7;
  localparam int SUB_W = 10;

  // Register map, byte addresses.
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_COMMAND = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // Config field positions and reset values.
  localparam int CFG_EDGE_BIT = 0;
  localparam int CFG_STOP_LSB = 1;
  localparam int CFG_RAMP_LSB = 4;
  localparam int CFG_POWER_LSB = 8;
  localparam logic CFG_EDGE_RST = 1'b0;
  localparam logic [2:0] CFG_STOP_RST = 3'h0;
  localparam logic [3:0] CFG_RAMP_RST = 4'h0;
  localparam logic [4:0] CFG_POWER_RST = 5'h17;
  localparam logic [4:0] POWER_CODE_MAX = 5'h17;

  // Status field positions.
  localparam int STS_STATE_LSB = 0;
  localparam int STS_SERIAL_BIT = 2;
  localparam int STS_CAL_BIT = 3;
  localparam int STS_KEY_BIT = 4;
  localparam int STS_ENV_LSB = 8;

  // Serial command patterns.
  localparam logic [15:0] CMD_SERIAL_CLEAR = 16'h8d00;
  localparam logic [15:0] CMD_SERIAL_DISABLE = 16'h8d02;
  localparam logic [15:0] CMD_CORE_REINIT = 16'hbd01;

  typedef enum logic [1:0] {
    ST_DORMANT,
    ST_OSC_WARMUP,
    ST_SYNTH_SETTLE,
    ST_RADIATE
  } ooktx_state_t;

  typedef struct packed {
    logic falling_start;
    logic [2:0] stop_sel;
    logic [3:0] ramp_sel;
    logic [4:0] power_code;
  } ooktx_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ooktx_bus_t;

endpackage

/* design/ooktx_ramp.sv */
`timescale 1ns/1ps
module ooktx_ramp
  import ooktx_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Control.
  input wire logic key_on,
  input wire logic clear,
  input wire logic [3:0] ramp_sel,
  // Envelope.
  output logic [ENV_W-1:0] envelope,
  output logic amp_enable
);

  localparam logic [ENV_W-1:0] ENV_MAX = ENV_W'(RAMP_STEPS);

  typedef struct packed {
    logic [ENV_W-1:0] level;
    logic [SUB_W-1:0] sub;
    logic amp_en;
  } ooktx_ramp_st_t;

  ooktx_ramp_st_t st;
  ooktx_ramp_st_t next_st;

  function automatic logic [SUB_W-1:0] step_last(input logic [3:0] sel);
    int n;
    n = (int'(sel) > RAMP_SEL_MAX) ? RAMP_SEL_MAX : int'(sel);
    step_last = SUB_W'((1 << (n - 1)) - 1);
  endfunction

  always_comb begin
    logic tick;
    tick = 1'b0;
    next_st = st;
    if (clear) begin
      next_st.level = '0;
      next_st.sub = '0;
    end else if (ramp_sel == 4'h0) begin
      next_st.level = key_on ? ENV_MAX : '0;
      next_st.sub = '0;
    end else if ((key_on && st.level != ENV_MAX) ||
                 (!key_on && st.level != '0)) begin
      tick = (st.sub == step_last(ramp_sel));
      next_st.sub = tick ? '0 : st.sub + 1'b1;
      if (tick) begin
        next_st.level = key_on ? st.level + 1'b1 : st.level - 1'b1;
      end
    end else begin
      next_st.sub = '0;
    end
    next_st.amp_en = (next_st.level != '0);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign envelope = st.level;
  assign amp_enable = st.amp_en;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_zero_ramp_jump: assert property (
    (ramp_sel == 4'h0 && !clear && key_on) |=> (envelope == ENV_MAX))
    else $error("zero ramp setting did not jump to full level");

  a_ramp_one_step: assert property (
    (ramp_sel != 4'h0 && !clear) |=>
      (envelope - $past(envelope) <= 7'h01 ||
       $past(envelope) - envelope <= 7'h01))
    else $error("envelope moved more than one step");

endmodule

/* design/ooktx_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - Four working states: dormant, oscillator warm-up, settle, radiate.
// - Dormant keeps oscillator, synthesizer and key off; data-pin edge detection and the re-initialise countdown run.
// - Configured rising or falling start edge in dormant starts warm-up.
// - Synthesizer settles about 370 us; no keying before it ends.
// - Radiate keys the amplifier on and off from the data level.
// - Data low for 20..90 ms (10 ms steps) ends transmission.
// - Core re-initialise during radiation stops transmission within 1 ms.
// - Rising mode: data ignored until settling ends; host waits.
// - Falling mode: data held low in warm-up, ignored in settle.
// - Ramp time is zero or 1..1024 us powers of two.
// - Ramp-down lasts as long as ramp-up.
// - Output power code -10..+13 dBm in 1 dB steps.
// - Serial clear command blocks start edges until serial disable.
// - Core re-initialise resets state, timers and envelope but keeps config and serial side, then dormant.
// - Serial disable command re-enables start edge detection.
module ooktx_ctrl
  import ooktx_pkg::*;
#(
  parameter int OSC_CYC = OSC_WARMUP_CYC,
  parameter int SETTLE_CYC = SYNTH_SETTLE_CYC,
  parameter int STOP_CYC = STOP_STEP_CYC,
  parameter int CAL_CYC = REINIT_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Data pin from the host.
  input wire logic data_pin,
  // Register port.
  input wire ooktx_bus_t bus,
  output logic [31:0] rdata,
  // Radio control.
  output ooktx_state_t tx_state,
  output logic osc_enable,
  output logic synth_enable,
  output logic power_amp_key,
  output logic power_amp_enable,
  output logic [ENV_W-1:0] power_amp_envelope,
  output logic [4:0] power_amp_level
);

  typedef struct packed {
    ooktx_state_t state;
    logic data_s1;
    logic data_s2;
    logic data_prev;
    logic [TIMER_W-1:0] timer;
    logic [IDLE_W-1:0] idle;
    logic [CAL_W-1:0] cal;
    logic serial_active;
    ooktx_cfg_t cfg;
    logic [31:0] rdata;
    logic key;
    logic osc_en;
    logic synth_en;
  } ooktx_ctrl_st_t;

  ooktx_ctrl_st_t st;
  ooktx_ctrl_st_t next_st;
  logic [ENV_W-1:0] env;
  logic amp_en;

  function automatic logic [IDLE_W-1:0] stop_limit(input logic [2:0] sel);
    stop_limit = IDLE_W'((int'(sel) + STOP_SEL_BASE) * STOP_CYC);
  endfunction

  function automatic logic hit(input logic wr, input logic [7:0] addr,
                               input logic [7:0] reg_addr);
    hit = wr && (addr == reg_addr);
  endfunction

  localparam logic [TIMER_W-1:0] OSC_LAST = TIMER_W'(OSC_CYC - 1);
  localparam logic [TIMER_W-1:0] SETTLE_LAST = TIMER_W'(SETTLE_CYC - 1);
  localparam logic [CAL_W-1:0] CAL_LOAD = CAL_W'(CAL_CYC);

  logic cmd_wr;
  logic cmd_clear;
  logic cmd_disable;
  logic cmd_reinit;
  logic start_edge;
  logic edge_armed;

  always_comb begin
    cmd_wr = hit(bus.wr, bus.addr, REG_COMMAND);
    cmd_clear = cmd_wr && (bus.wdata[15:0] == CMD_SERIAL_CLEAR);
    cmd_disable = cmd_wr && (bus.wdata[15:0] == CMD_SERIAL_DISABLE);
    cmd_reinit = cmd_wr && (bus.wdata[15:0] == CMD_CORE_REINIT);
    start_edge = st.cfg.falling_start ? (st.data_prev && !st.data_s2)
                                      : (!st.data_prev && st.data_s2);
    edge_armed = !st.serial_active && (st.cal == '0);
  end

  always_comb begin
    next_st = st;
    // The edge detector compares the second stage of the synchroniser with its delayed copy data_prev.
    next_st.data_s1 = data_pin;
    next_st.data_s2 = st.data_s1;
    next_st.data_prev = st.data_s2;

    if (hit(bus.wr, bus.addr, REG_CONFIG)) begin
      next_st.cfg.falling_start = bus.wdata[CFG_EDGE_BIT];
      next_st.cfg.stop_sel = bus.wdata[CFG_STOP_LSB +: 3];
      next_st.cfg.ramp_sel = bus.wdata[CFG_RAMP_LSB +: 4];
      next_st.cfg.power_code =
        (bus.wdata[CFG_POWER_LSB +: 5] > POWER_CODE_MAX) ?
        POWER_CODE_MAX : bus.wdata[CFG_POWER_LSB +: 5];
    end

    if (cmd_clear) begin
      next_st.serial_active = 1'b1;
    end
    if (cmd_disable) begin
      next_st.serial_active = 1'b0;
    end

    if (st.cal != '0) begin
      next_st.cal = st.cal - 1'b1;
    end

    case (st.state)
      ST_DORMANT: begin
        next_st.timer = '0;
        next_st.idle = '0;
        if (start_edge && edge_armed) begin
          next_st.state = ST_OSC_WARMUP;
        end
      end
      ST_OSC_WARMUP: begin
        if (st.timer == OSC_LAST) begin
          next_st.timer = '0;
          next_st.state = ST_SYNTH_SETTLE;
        end else begin
          next_st.timer = st.timer + 1'b1;
        end
      end
      ST_SYNTH_SETTLE: begin
        if (st.timer == SETTLE_LAST) begin
          next_st.timer = '0;
          next_st.idle = '0;
          next_st.state = ST_RADIATE;
        end else begin
          next_st.timer = st.timer + 1'b1;
        end
      end
      ST_RADIATE: begin
        if (st.data_s2) begin
          next_st.idle = '0;
        end else if (st.idle >= stop_limit(st.cfg.stop_sel) - 1'b1) begin
          next_st.idle = '0;
          next_st.state = ST_DORMANT;
        end else begin
          next_st.idle = st.idle + 1'b1;
        end
      end
      default: begin
        next_st.state = ST_DORMANT;
      end
    endcase

    if (cmd_reinit) begin
      next_st.state = ST_DORMANT;
      next_st.timer = '0;
      next_st.idle = '0;
      next_st.cal = CAL_LOAD;
    end

    next_st.key = (next_st.state == ST_RADIATE) && st.data_s2;
    next_st.osc_en = (next_st.state != ST_DORMANT);
    next_st.synth_en = (next_st.state == ST_SYNTH_SETTLE) ||
                       (next_st.state == ST_RADIATE);

    next_st.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        REG_CONFIG: begin
          next_st.rdata[CFG_EDGE_BIT] = st.cfg.falling_start;
          next_st.rdata[CFG_STOP_LSB +: 3] = st.cfg.stop_sel;
          next_st.rdata[CFG_RAMP_LSB +: 4] = st.cfg.ramp_sel;
          next_st.rdata[CFG_POWER_LSB +: 5] = st.cfg.power_code;
        end
        REG_STATUS: begin
          next_st.rdata[STS_STATE_LSB +: 2] = st.state;
          next_st.rdata[STS_SERIAL_BIT] = st.serial_active;
          next_st.rdata[STS_CAL_BIT] = (st.cal != '0);
          next_st.rdata[STS_KEY_BIT] = st.key;
          next_st.rdata[STS_ENV_LSB +: ENV_W] = env;
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st.state <= ST_DORMANT;
      st.data_s1 <= 1'b0;
      st.data_s2 <= 1'b0;
      st.data_prev <= 1'b0;
      st.timer <= '0;
      st.idle <= '0;
      st.cal <= '0;
      st.serial_active <= 1'b0;
      st.cfg.falling_start <= CFG_EDGE_RST;
      st.cfg.stop_sel <= CFG_STOP_RST;
      st.cfg.ramp_sel <= CFG_RAMP_RST;
      st.cfg.power_code <= CFG_POWER_RST;
      st.rdata <= '0;
      st.key <= 1'b0;
      st.osc_en <= 1'b0;
      st.synth_en <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ooktx_ramp u_ramp (
    .clock(clock),
    .rst_n(rst_n),
    .key_on(st.key),
    .clear(cmd_reinit),
    .ramp_sel(st.cfg.ramp_sel),
    .envelope(env),
    .amp_enable(amp_en)
  );

  assign rdata = st.rdata;
  assign tx_state = st.state;
  assign osc_enable = st.osc_en;
  assign synth_enable = st.synth_en;
  assign power_amp_key = st.key;
  assign power_amp_enable = amp_en;
  assign power_amp_envelope = env;
  assign power_amp_level = st.cfg.power_code;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_start_edge_warm: assert property (
    (st.state == ST_DORMANT && start_edge && edge_armed && !cmd_reinit)
      |=> (st.state == ST_OSC_WARMUP) ##0 osc_enable ##0 !synth_enable)
    else $error("valid start edge did not begin warm-up");

  a_dormant_off: assert property (
    (st.state == ST_DORMANT && !(start_edge && edge_armed))
      |=> !osc_enable && !synth_enable && !power_amp_key)
    else $error("block left on while dormant");

  a_no_key_early: assert property (
    (st.state != ST_RADIATE) ##1 (st.state != ST_RADIATE) |-> !power_amp_key)
    else $error("amplifier keyed before settling ended");

  a_key_follows: assert property (
    (st.state == ST_RADIATE && !cmd_reinit && st.data_s2)
      |=> power_amp_key)
    else $error("amplifier not keyed on high data");

  a_idle_stop: assert property (
    (st.state == ST_RADIATE && !st.data_s2 &&
     st.idle == stop_limit(st.cfg.stop_sel) - 1'b1)
      |=> (st.state == ST_DORMANT) ##1 !power_amp_key)
    else $error("idle-low timeout did not end transmission");

  a_reinit_stop: assert property (
    cmd_reinit |=> (st.state == ST_DORMANT && st.cal == CAL_LOAD)
      ##1 (!power_amp_key && !osc_enable))
    else $error("re-initialise did not stop transmission");

  a_clear_blocks: assert property (
    (st.serial_active && st.state == ST_DORMANT) |=> st.state == ST_DORMANT)
    else $error("start edge accepted while serial side active");

  a_disable_rearm: assert property (
    (cmd_disable && !cmd_clear) |=> !st.serial_active)
    else $error("serial disable did not rearm edge detection");

  a_no_restart: assert property (
    (st.state == ST_RADIATE && start_edge && !cmd_reinit)
      |=> st.state != ST_OSC_WARMUP)
    else $error("start edge restarted warm-up");

  a_dormant_still: assert property (
    (st.state == ST_DORMANT) |=> (st.timer == '0 && st.idle == '0))
    else $error("timers ran while dormant");

  a_warmup_len: assert property (
    (st.state == ST_OSC_WARMUP && st.timer == OSC_LAST && !cmd_reinit)
      |=> st.state == ST_SYNTH_SETTLE && st.timer == '0)
    else $error("warm-up did not hand over to settle");

  a_settle_to_tx: assert property (
    (st.state == ST_SYNTH_SETTLE && st.timer == SETTLE_LAST && !cmd_reinit)
      |=> st.state == ST_RADIATE && synth_enable)
    else $error("settle did not hand over to radiate");

  a_settle_ignored: assert property (
    (st.state == ST_SYNTH_SETTLE) |-> !power_amp_key)
    else $error("data keyed the amplifier during settle");

  a_warmup_count: assert property (
    (st.state == ST_OSC_WARMUP && st.timer != OSC_LAST && !cmd_reinit)
      |=> st.state == ST_OSC_WARMUP && st.timer == $past(st.timer) + 1'b1)
    else $error("warm-up left early or miscounted");

  a_cal_blocks: assert property (
    (st.state == ST_DORMANT && st.cal != '0) |=> st.state == ST_DORMANT)
    else $error("start edge accepted during re-initialise");

  a_warmup_outputs: assert property (
    (st.state == ST_OSC_WARMUP) |-> osc_enable && !synth_enable)
    else $error("oscillator or synthesizer wrong in warm-up");

  a_power_clamp: assert property (
    power_amp_level <= POWER_CODE_MAX)
    else $error("power code above the top setting");

endmodule

/* dv/ooktx_host.sv */
`timescale 1ns/1ps
module ooktx_host (
  // Clock.
  input wire logic clock,
  // Data pin toward the transmitter.
  output logic data_pin
);
  initial data_pin = 1'b0;

  // The pin moves only after an edge, so the block never sees a race.
  task automatic level(input logic v);
    @(posedge clock);
    data_pin <= v;
    #1;
  endtask

  // Rising mode is the usual choice; falling mode is kept for coverage.
  // preferred start mode
  task automatic start(input logic falling);
    level(falling);
    repeat (6) @(posedge clock);
    level(!falling);
    // back low one cycle after the rising edge
    // A pin left high would key the amplifier at the first radiate cycle.
    if (!falling) level(1'b0);
  endtask
endmodule

/* dv/tb_ooktx_ctrl.sv */
`timescale 1ns/1ps
module tb_ooktx_ctrl;
  import ooktx_pkg::*;
  localparam int OSC = 20;
  localparam int SET = 15;
  localparam int STP = 40;
  localparam int CAL = 30;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  ooktx_bus_t bus = '0;
  logic data_pin;
  logic [31:0] rdata;
  logic [31:0] d;
  ooktx_state_t tx_state;
  logic osc_enable, synth_enable, key, amp_en;
  logic [ENV_W-1:0] env;
  logic [4:0] level;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  ooktx_ctrl #(.OSC_CYC(OSC), .SETTLE_CYC(SET), .STOP_CYC(STP),
    .CAL_CYC(CAL)) u_ooktx_ctrl (.clock(clock), .rst_n(rst_n),
    .data_pin(data_pin), .bus(bus), .rdata(rdata), .tx_state(tx_state),
    .osc_enable(osc_enable), .synth_enable(synth_enable),
    .power_amp_key(key), .power_amp_enable(amp_en),
    .power_amp_envelope(env), .power_amp_level(level));
  ooktx_host u_ooktx_host (.clock(clock), .data_pin(data_pin));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // A hung wait loop would otherwise run forever.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      stop_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock);
    bus <= '0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic wait_st(input ooktx_state_t s, input int lim, output int n);
    n = 0;
    while (tx_state !== s && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(tx_state, s);
  endtask

  task automatic wait_env(input logic [ENV_W-1:0] t, output int n);
    n = 0;
    while (env !== t && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask

  function automatic logic [31:0] cfg(input logic f, input logic [2:0] s,
    input logic [3:0] r, input logic [4:0] p);
    return {19'h0, p, r, s, f};
  endfunction

  task automatic reg_test;
    check({tx_state, osc_enable, synth_enable, key, amp_en, env, level},
      {2'h0, 4'h0, 7'h0, 5'h17});
    rd(REG_CONFIG);
    check(d, 32'h1700);
    @(posedge clock);
    #1 check(rdata, 32'h0);
    rd(REG_COMMAND);
    check(d, 32'h0);
    wr(8'hf3, 32'hffff_ffff);
    rd(8'hf3);
    check(d, 32'h0);
    rd(REG_CONFIG);
    check(d, 32'h1700);
    wr(REG_CONFIG, cfg(1'b0, 3'h0, 4'h0, 5'h1f));
    rd(REG_CONFIG);
    check(d[12:8], 5'h17);
    wr(REG_CONFIG, cfg(1'b0, 3'h0, 4'h0, 5'h00));
    @(posedge clock);
    #1 check(level, 5'h00);
  endtask

  task automatic run_tx(input logic f, input logic [2:0] s,
    input logic [3:0] r);
    int n, u, dn, e, lim;
    e = (r == 0) ? 0 : RAMP_STEPS << (r - 1);
    lim = (s + 2) * STP;
    wr(REG_CONFIG, cfg(f, s, r, 5'h17));
    u_ooktx_host.start(f);
    wait_st(ST_OSC_WARMUP, 6, n);
    check({osc_enable, synth_enable, key}, 3'h4);
    wait_st(ST_SYNTH_SETTLE, 100, n);
    check(n, OSC);
    check({synth_enable, key, amp_en}, 3'h4);
    wait_st(ST_RADIATE, 100, n);
    check(n, SET);
    rd(REG_STATUS);
    check(d[1:0], 2'h3);
    u_ooktx_host.level(1'b1);
    wait_env(ENV_W'(RAMP_STEPS), u);
    check({key, amp_en}, 2'h3);
    u_ooktx_host.level(1'b0);
    wait_env('0, dn);
    check({key, amp_en}, 2'h0);
    check(u >= e + 2 && u <= e + 7, 1'b1);
    check((u > dn ? u - dn : dn - u) <= 1, 1'b1);
    u_ooktx_host.level(1'b1);
    repeat (6) @(posedge clock);
    #1 check(tx_state, ST_RADIATE);
    u_ooktx_host.level(1'b0);
    wait_st(ST_DORMANT, lim + 8, n);
    check(n >= lim && n <= lim + 6, 1'b1);
    check({osc_enable, synth_enable, key}, 3'h0);
  endtask

  task automatic serial_test;
    int n;
    wr(REG_CONFIG, cfg(1'b0, 3'h7, 4'h0, 5'h17));
    wr(REG_COMMAND, {16'h0, CMD_SERIAL_CLEAR});
    u_ooktx_host.start(1'b0);
    repeat (6) @(posedge clock);
    #1 check(tx_state, ST_DORMANT);
    rd(REG_STATUS);
    check(d[2], 1'b1);
    u_ooktx_host.level(1'b0);
    wr(REG_COMMAND, {16'h0, CMD_SERIAL_DISABLE});
    u_ooktx_host.level(1'b1);
    wait_st(ST_OSC_WARMUP, 6, n);
    wr(REG_COMMAND, {16'h0, CMD_CORE_REINIT});
    wait_st(ST_DORMANT, 2, n);
    repeat (CAL) @(posedge clock);
  endtask

  task automatic reinit_test;
    int n;
    wr(REG_CONFIG, cfg(1'b0, 3'h7, 4'h0, 5'h17));
    u_ooktx_host.start(1'b0);
    wait_st(ST_RADIATE, 60, n);
    wr(REG_COMMAND, {16'h0, CMD_CORE_REINIT});
    wait_st(ST_DORMANT, 2, n);
    repeat (2) @(posedge clock);
    #1 check({osc_enable, synth_enable, key}, 3'h0);
    rd(REG_STATUS);
    check(d[4:0], 5'h08);
    u_ooktx_host.start(1'b0);
    repeat (6) @(posedge clock);
    #1 check(tx_state, ST_DORMANT);
    rd(REG_CONFIG);
    check(d, 32'h170e);
    repeat (CAL) @(posedge clock);
    u_ooktx_host.start(1'b0);
    wait_st(ST_OSC_WARMUP, 6, n);
    wr(REG_COMMAND, {16'h0, CMD_CORE_REINIT});
    wait_st(ST_DORMANT, 2, n);
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1 reg_test();
    for (int s = 0; s < 8; s++) begin
      run_tx(1'b0, 3'(s), 4'h0);
    end
    run_tx(1'b0, 3'h7, 4'h1);
    run_tx(1'b0, 3'h7, 4'h2);
    run_tx(1'b1, 3'h0, 4'h0);
    serial_test();
    reinit_test();
    stop_test();
  end
endmodule
